// file: cms_map.svh
// register map, field positions, reset values and timing counts for the clock mode switch
// Contract
// - fll reference change between internal and external may overshoot fll frequency
// - in engaged fll modes the overshoot reaches the system clock
// - only external-fll to internal-fll mode changes, either way, are exposed
// - fll is disabled in low power bypass and pll modes, avoiding overshoot
// - status shows internal reference before the multiplexer has really switched
// - multiplexer switches 2 slow oscillator plus 2 external cycles after status
// - pll select in external pll or low power modes enables both oscillators; the code leaves out the low power internal mode
// - fast oscillator startup on that path may exceed low power run frequency
// - with wake select set any interrupt leaves low power run or stop to run
`ifndef CMS_MAP_SVH
`define CMS_MAP_SVH
`define CMS_ADDR_W        4
`define CMS_ADDR_CTRL     4'h0
`define CMS_ADDR_DCO      4'h4
`define CMS_ADDR_STATUS   4'h8
`define CMS_ADDR_POWER    4'hC
`define CMS_MODE_LSB      0
`define CMS_REF_BIT       4
`define CMS_PLL_BIT       5
`define CMS_REFA_BIT      6
`define CMS_REFB_BIT      7
`define CMS_FINE_BIT      0
`define CMS_RANGE_LSB     1
`define CMS_WAKE_BIT      0
`define CMS_STOP_BIT      1
`define CMS_RST_MODE      3'h0
`define CMS_RST_RANGE     2'h0
`define CMS_SYNC_CYCLES   2'h2
`endif

// file: cms_pkg.sv
// types shared by the clock mode switch logic
package cms_pkg;
	typedef enum logic [2:0] {
		CMS_FEI, CMS_FEE, CMS_FBI, CMS_FBE, CMS_BYPASSED_LOW_POWER_INTERNAL_MODE, CMS_BYPASSED_LOW_POWER_EXTERNAL_MODE, CMS_PBE, CMS_PEE
	} cms_mode_type;
	typedef enum logic [1:0] {
		CMS_SW_IDLE, CMS_SW_SLOW, CMS_SW_EXT
	} cms_sw_type;
	typedef enum logic [1:0] {
		CMS_PWR_RUN, CMS_PWR_VERY_LOW_POWER_RUN, CMS_PWR_VERY_LOW_POWER_STOP
	} cms_pwr_type;
endpackage

// file: cms_clock_mode_switch.sv
// clock mode switch control with avalon register slave
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "cms_map.svh"
module cms_clock_mode_switch import cms_pkg::*; (
	input  wire logic        i_core_clk,
	input  wire logic        i_sys_rst,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_slow_irc_clk,
	input  wire logic        i_ext_ref_clk,
	input  wire logic        i_irq,
	output logic             o_fll_enable,
	output logic             o_fll_drives_sys,
	output logic             o_fll_ref_internal,
	output logic             o_overshoot_risk,
	output logic             o_pll_enable,
	output logic             o_osc_a_enable,
	output logic             o_osc_b_enable,
	output logic             o_very_low_power_run_overspeed,
	output logic             o_run_mode,
	output logic             o_very_low_power_run_mode,
	output logic             o_very_low_power_stop_mode
);
	// all state in one struct: control fields written by software, the
	// reference switch sequencer, the pin synchronisers, the bus handshake
	// and the power state. one comb process builds the next copy, one
	// flop process registers it, so no field has a second driver.
	typedef struct packed {
		cms_mode_type mode;
		logic         ref_sel;
		logic         pll_sel;
		logic         refa;
		logic         refb;
		logic         fine;
		logic [1:0]   range;
		logic         wake;
		logic         ref_status;
		logic         mux_internal;
		cms_sw_type   sw;
		logic [1:0]   cnt;
		logic [2:0]   slow_sync;
		logic [2:0]   ext_sync;
		logic         acked;
		logic [31:0]  rdata;
		cms_pwr_type  pwr;
		logic         irq_seen;
		logic         overspeed;
	} cms_state_type;
	cms_state_type s_q, s_d;
	logic          slow_edge;
	logic          ext_edge;
	logic          fll_on;
	logic          hit;

	// rising edges counted when the second stage is high and the third still low
	assign slow_edge = s_q.slow_sync[1] & ~s_q.slow_sync[2];
	assign ext_edge  = s_q.ext_sync[1] & ~s_q.ext_sync[2];
	// fll off in low power bypass and pll modes
	assign fll_on = (s_q.mode == CMS_FEI) || (s_q.mode == CMS_FEE) ||
		(s_q.mode == CMS_FBI) || (s_q.mode == CMS_FBE);
	// request seen once; acked blocks a second take on the held request
	assign hit = (i_avs_read | i_avs_write) & ~s_q.acked;

	// next state
	// bus handshake: edge 1 sees the request and drops waitrequest,
	// edge 2 is where the master samples it low; writes land there and
	// read data, registered at edge 1, stands there.
	// the reference sequencer counts slow edges first, then external
	// edges, so the status bit leads the real multiplexer change.
	// clearing ref_select drops status and multiplexer at once; that
	// direction is not modelled with any delay.
	always_comb begin
		s_d = s_q;
		s_d.slow_sync = {s_q.slow_sync[1:0], i_slow_irc_clk};
		s_d.ext_sync  = {s_q.ext_sync[1:0], i_ext_ref_clk};
		s_d.acked = hit;
		s_d.rdata = 32'h0;
		// write lands on the edge where the master sees waitrequest low;
		// acked marks that edge, one after the request was first seen
		if (s_q.acked && i_avs_write) begin
			if (i_avs_address == `CMS_ADDR_CTRL) begin
				s_d.mode    = cms_mode_type'(i_avs_writedata[`CMS_MODE_LSB +: 3]);
				s_d.ref_sel = i_avs_writedata[`CMS_REF_BIT];
				s_d.pll_sel = i_avs_writedata[`CMS_PLL_BIT];
				s_d.refa    = i_avs_writedata[`CMS_REFA_BIT];
				s_d.refb    = i_avs_writedata[`CMS_REFB_BIT];
			end else if (i_avs_address == `CMS_ADDR_DCO) begin
				s_d.fine  = i_avs_writedata[`CMS_FINE_BIT];
				s_d.range = i_avs_writedata[`CMS_RANGE_LSB +: 2];
			end else if (i_avs_address == `CMS_ADDR_POWER) begin
				s_d.wake = i_avs_writedata[`CMS_WAKE_BIT];
				if (i_avs_writedata[`CMS_STOP_BIT]) begin
					s_d.pwr = CMS_PWR_VERY_LOW_POWER_STOP;
				end else if (s_q.pwr == CMS_PWR_RUN) begin
					s_d.pwr = CMS_PWR_VERY_LOW_POWER_RUN;
				end
			end
		end
		// read data registered on the first edge, standing on the second
		if (hit && i_avs_read) begin
			if (i_avs_address == `CMS_ADDR_CTRL) begin
				s_d.rdata = {24'h0, s_q.refb, s_q.refa, s_q.pll_sel, s_q.ref_sel,
					1'b0, s_q.mode};
			end else if (i_avs_address == `CMS_ADDR_DCO) begin
				s_d.rdata = {29'h0, s_q.range, s_q.fine};
			end else if (i_avs_address == `CMS_ADDR_STATUS) begin
				s_d.rdata = {29'h0, s_q.overspeed, s_q.mux_internal, s_q.ref_status};
			end else if (i_avs_address == `CMS_ADDR_POWER) begin
				s_d.rdata = {28'h0, 2'(s_q.pwr), 1'b0, s_q.wake};
			end
		end
		// reference switch sequencing
		case (s_q.sw)
			CMS_SW_IDLE: begin
				if (s_q.ref_sel && !s_q.ref_status) begin
					s_d.ref_status = 1'b1;
					s_d.sw = CMS_SW_SLOW;
					s_d.cnt = `CMS_SYNC_CYCLES;
				end else if (!s_q.ref_sel && s_q.ref_status) begin
					s_d.ref_status = 1'b0;
					s_d.mux_internal = 1'b0;
				end
			end
			CMS_SW_SLOW: begin
				if (slow_edge) begin
					s_d.cnt = s_q.cnt - 2'h1;
				end
				if (slow_edge && s_q.cnt == 2'h1) begin
					s_d.sw = CMS_SW_EXT;
					s_d.cnt = `CMS_SYNC_CYCLES;
				end
			end
			CMS_SW_EXT: begin
				if (ext_edge) begin
					s_d.cnt = s_q.cnt - 2'h1;
				end
				// external clock still feeds the fll until here
				if (ext_edge && s_q.cnt == 2'h1) begin
					s_d.mux_internal = 1'b1;
					s_d.sw = CMS_SW_IDLE;
				end
			end
			default: s_d.sw = CMS_SW_IDLE;
		endcase
		// power mode exits on interrupt
		s_d.irq_seen = i_irq;
		s_d.overspeed = 1'b0;
		if (i_irq && !s_q.irq_seen) begin
			if (s_q.wake && s_q.pwr != CMS_PWR_RUN) begin
				s_d.pwr = CMS_PWR_RUN;
			end else if (s_q.pwr == CMS_PWR_VERY_LOW_POWER_STOP) begin
				s_d.pwr = CMS_PWR_VERY_LOW_POWER_RUN;
				// fast oscillator startup flagged, not prevented
				s_d.overspeed = (s_q.mode == CMS_BYPASSED_LOW_POWER_INTERNAL_MODE);
			end
		end
	end

	// state register
	// reset puts the fll in its internal engaged mode, run power state,
	// status clear; the synchronisers start low like the idle clock pins
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_q <= '{mode: CMS_FEI, sw: CMS_SW_IDLE, pwr: CMS_PWR_RUN,
				range: `CMS_RST_RANGE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// registered outputs
	// every port comes from a flop; status levels lag state by one edge.
	// waitrequest idles high so a master never sees a stale answer.
	// oscillator enables follow pll select in the external pll and low
	// power external modes whatever oscillator is really in use; clearing
	// the unused reference bit does not keep its enable down there.
	always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_avs_readdata     <= 32'h0;
			o_avs_waitrequest  <= 1'b1;
			o_fll_enable       <= 1'b0;
			o_fll_drives_sys   <= 1'b0;
			o_fll_ref_internal <= 1'b0;
			o_overshoot_risk   <= 1'b0;
			o_pll_enable       <= 1'b0;
			o_osc_a_enable     <= 1'b0;
			o_osc_b_enable     <= 1'b0;
			o_very_low_power_run_overspeed   <= 1'b0;
			o_run_mode         <= 1'b0;
			o_very_low_power_run_mode        <= 1'b0;
			o_very_low_power_stop_mode        <= 1'b0;
		end else begin
			o_avs_readdata     <= s_d.rdata;
			o_avs_waitrequest  <= ~hit;
			o_fll_enable       <= fll_on;
			o_fll_drives_sys   <= (s_q.mode == CMS_FEI) || (s_q.mode == CMS_FEE);
			o_fll_ref_internal <= s_q.mux_internal;
			// mux change while fll runs risks overshoot
			o_overshoot_risk   <= fll_on && (s_q.mux_internal != s_d.mux_internal);
			o_pll_enable       <= s_q.pll_sel;
			// pll select in the external pll and low power external modes wakes both oscillators
			o_osc_a_enable     <= (s_q.pll_sel && (s_q.mode == CMS_PBE ||
				s_q.mode == CMS_BYPASSED_LOW_POWER_EXTERNAL_MODE || s_q.mode == CMS_PEE)) || s_q.refa;
			o_osc_b_enable     <= (s_q.pll_sel && (s_q.mode == CMS_PBE ||
				s_q.mode == CMS_BYPASSED_LOW_POWER_EXTERNAL_MODE || s_q.mode == CMS_PEE)) || s_q.refb;
			o_very_low_power_run_overspeed   <= s_q.overspeed;
			o_run_mode         <= s_q.pwr == CMS_PWR_RUN;
			o_very_low_power_run_mode        <= s_q.pwr == CMS_PWR_VERY_LOW_POWER_RUN;
			o_very_low_power_stop_mode        <= s_q.pwr == CMS_PWR_VERY_LOW_POWER_STOP;
		end
	end
endmodule // cms_clock_mode_switch

// file: cms_clock_mode_switch_sva.sv
// checker for the clock mode switch ports
`timescale 1ns/100ps
module cms_checker (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_avs_read,
	input wire logic i_irq,
	input wire logic o_avs_waitrequest,
	input wire logic o_fll_enable,
	input wire logic o_fll_drives_sys,
	input wire logic o_overshoot_risk,
	input wire logic o_very_low_power_run_overspeed,
	input wire logic o_run_mode,
	input wire logic o_very_low_power_run_mode,
	input wire logic o_very_low_power_stop_mode
);
	// single domain, so one clock and reset for all
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	chk_wait_one: assert property
		($fell(o_avs_waitrequest) |=> o_avs_waitrequest) else $error("wait low too long");
	chk_read_answer: assert property
		($rose(i_avs_read) |=> !o_avs_waitrequest) else $error("read not answered");
	chk_fll_drive: assert property
		(o_fll_drives_sys |-> o_fll_enable) else $error("fll drives while off");
	chk_risk_pulse: assert property
		(o_overshoot_risk |=> !o_overshoot_risk) else $error("risk pulse too long");
	chk_risk_fll: assert property
		(o_overshoot_risk |-> o_fll_enable || $past(o_fll_enable)) else $error("risk with fll off");
	chk_speed_pulse: assert property
		(o_very_low_power_run_overspeed |-> !o_fll_enable ##1 !o_very_low_power_run_overspeed) else $error("bad overspeed");
	chk_power_one: assert property
		($onehot0({o_run_mode, o_very_low_power_run_mode, o_very_low_power_stop_mode})) else $error("power not one hot");
	chk_irq_leave: assert property
		($rose(i_irq) && o_very_low_power_stop_mode |-> ##[1:4] !o_very_low_power_stop_mode) else $error("stop not left");
	cover property (o_overshoot_risk);
	cover property (o_very_low_power_run_overspeed);
	cover property ($rose(o_run_mode));
endmodule // cms_checker
bind cms_clock_mode_switch cms_checker u_chk (.*);

// file: clock_mode_switch_control_bench.sv
// self-checking bench for the clock mode switch
`timescale 1ns/100ps
module clock_mode_switch_control_bench;
	logic        i_core_clk = 0, i_sys_rst = 1, i_avs_read = 0, i_avs_write = 0, i_irq = 0;
	logic        i_slow_irc_clk = 0, i_ext_ref_clk = 0;
	logic [3:0]  i_avs_address = 4'h0;
	logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd_q;
	logic        o_avs_waitrequest, o_fll_enable, o_fll_drives_sys, o_fll_ref_internal;
	logic        o_overshoot_risk, o_pll_enable, o_osc_a_enable, o_osc_b_enable;
	logic        o_very_low_power_run_overspeed, o_run_mode, o_very_low_power_run_mode, o_very_low_power_stop_mode;
	int          miscompares = 0, n_checks = 0, n_risk = 0, n_spd = 0;
	cms_clock_mode_switch uut (.*);
	// reference clocks unrelated to the core clock
	initial forever #12.5 i_core_clk = ~i_core_clk;
	always #125 i_slow_irc_clk = ~i_slow_irc_clk;
	always #35 i_ext_ref_clk = ~i_ext_ref_clk;
	// one-cycle pulses are counted where they stand
	always @(posedge i_core_clk) begin
		n_risk += (o_overshoot_risk === 1'b1);
		n_spd += (o_very_low_power_run_overspeed === 1'b1);
	end
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// request held until waitrequest is sampled low
	task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int t;
		@(posedge i_core_clk);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= wr;
		i_avs_read <= !wr;
		t = 0;
		do begin
			@(posedge i_core_clk);
			t++;
		end while (o_avs_waitrequest !== 1'b0 && t < 40);
		rd_q = o_avs_readdata;
		if (t >= 40) begin
			miscompares++;
			close_out;
		end
		i_avs_write <= 0;
		i_avs_read <= 0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
		acc(0, a, 32'h0);
		chk(nm, rd_q, exp);
	endtask
	// irq held long enough for the wake to land
	task automatic irq;
		@(posedge i_core_clk);
		i_irq <= 1;
		repeat (6) @(posedge i_core_clk);
		i_irq <= 0;
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100us;
		miscompares++;
		close_out;
	end
	initial begin
		repeat (12) @(posedge i_core_clk);
		i_sys_rst <= 0;
		// run level launched on the first edge, looked at on the second
		repeat (2) @(posedge i_core_clk);
		chk("run", o_run_mode, 1);
		rd(4'h0, 32'h0, "ctrl");
		rd(4'h8, 32'h0, "status");
		acc(1, 4'h1, 32'hFF);
		rd(4'h1, 32'h0, "unmapped");
		// every clock mode with pll_select set
		for (int m = 0; m < 8; m++) begin
			acc(1, 4'h0, 32'h20 | m);
			repeat (2) @(posedge i_core_clk);
			chk("fll_on", o_fll_enable, m < 4);
			chk("fll_sys", o_fll_drives_sys, m < 2);
			chk("osc", {o_osc_a_enable, o_osc_b_enable}, m > 4 ? 3 : 0);
			chk("pll", o_pll_enable, 1);
		end
		acc(1, 4'h0, 32'h1);
		acc(1, 4'h4, 32'h1);
		acc(1, 4'h0, 32'h10);
		rd(4'h8, 32'h1, "early");
		chk("mux_early", o_fll_ref_internal, 0);
		repeat (60) @(posedge i_core_clk);
		rd(4'h8, 32'h3, "late");
		chk("mux_late", o_fll_ref_internal, 1);
		acc(1, 4'h4, 32'h0);
		chk("risk", n_risk > 0, 1);
		acc(1, 4'h0, 32'h0);
		rd(4'h8, 32'h0, "cleared");
		// low power entry in the internal bypass mode, then both wakes
		acc(1, 4'h0, 32'h4);
		acc(1, 4'hC, 32'h0);
		acc(1, 4'hC, 32'h2);
		repeat (2) @(posedge i_core_clk);
		chk("very_low_power_stop", o_very_low_power_stop_mode, 1);
		irq;
		chk("very_low_power_run", o_very_low_power_run_mode, 1);
		chk("speed", n_spd, 1);
		acc(1, 4'hC, 32'h3);
		irq;
		chk("run", o_run_mode, 1);
		// stop to low power run in the external bypass mode is safe
		acc(1, 4'h0, 32'h5);
		acc(1, 4'hC, 32'h2);
		irq;
		chk("very_low_power_run_ext", o_very_low_power_run_mode, 1);
		chk("speed_ext", n_spd, 1);
		close_out;
	end
endmodule // clock_mode_switch_control_bench
